// *** ddr2_burst_defs.svh ***
`ifndef DDR2_BURST_DEFS_SVH
`define DDR2_BURST_DEFS_SVH

// Bit positions inside the synchroniser bus
`define DDR2_SYNC_K 0
`define DDR2_SYNC_KN 1
`define DDR2_SYNC_C 2
`define DDR2_SYNC_CN 3
`define DDR2_SYNC_LOAD_N 4
`define DDR2_SYNC_READ 5
`define DDR2_SYNC_USE_C 6
`define DDR2_SYNC_STRAP 7
`define DDR2_SYNC_TCK 8
`define DDR2_SYNC_TMS 9
`define DDR2_SYNC_TDI 10
`define DDR2_SYNC_LSB 11
`define DDR2_SYNC_FIXED 12

// Idle level of the four clock pins: true clocks low, complements high
`define DDR2_CLK_IDLE 4'hA

// Default geometry
`define DDR2_DATA_W 36
`define DDR2_LANES 4
`define DDR2_ADDR_W 19

// Output half-clock edges from address latch to first read word
`define DDR2_RL_HALF_PLL 3'h3
`define DDR2_RL_HALF_DLL 3'h2

// Test access port instruction register
`define DDR2_TAP_IR_W 3
`define DDR2_TAP_IR_RESET 3'h7
`define DDR2_TAP_IR_CAPTURE 3'h1

`endif

// *** ddr2_burst_pkg.sv ***
package ddr2_burst_pkg;

  typedef enum logic [1:0] {
    WR_IDLE,
    WR_WORD0,
    WR_WORD1
  } wr_phase_type;

  typedef enum logic [3:0] {
    TAP_RESET,
    TAP_IDLE,
    TAP_SEL_DR,
    TAP_CAP_DR,
    TAP_SHIFT_DR,
    TAP_EXIT1_DR,
    TAP_PAUSE_DR,
    TAP_EXIT2_DR,
    TAP_UPD_DR,
    TAP_SEL_IR,
    TAP_CAP_IR,
    TAP_SHIFT_IR,
    TAP_EXIT1_IR,
    TAP_PAUSE_IR,
    TAP_EXIT2_IR,
    TAP_UPD_IR
  } tap_state_type;

endpackage

// *** ddr2_burst2_sram_port.sv ***
// Functional notes
// RQ1: One address per burst, alternate clock edges
// RQ2: Write word0 on true, word1 on complement
// RQ3: Read words on output clocks, else main
// RQ4: Burst bit from address LSB, two words
// RQ5: Strap high: first word after 1.5 cycles
// RQ6: Strap low: first word after 1 cycle
// RQ7: Echo clocks toggle aligned with read data
// RQ8: Shared data bus, never both driving
// RQ9: Synchronous inputs pass input registers first
// RQ10: Read data comes from output registers
// RQ11: Array writes are self-timed internally
// RQ12: Act on rising edges only; the test port still updates tdo on the falling edge of tck
// RQ13: Boundary-scan test access port provided
// RQ14: Controller pulls load strobe low per burst
// RQ15: Byte masks per word, unselected lanes kept
// RQ16: Data outputs released when no read
// RQ17: Controller drives direction with load strobe
`include "ddr2_burst_defs.svh"

module ddr2_burst2_sram_port #(
  parameter int DATA_W = `DDR2_DATA_W,
  parameter int LANES = `DDR2_LANES,
  parameter int ADDR_W = `DDR2_ADDR_W
) (
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  input wire logic k_clk_in,
  input wire logic k_clk_n_in,
  input wire logic c_clk_in,
  input wire logic c_clk_n_in,
  input wire logic out_clock_used_in,
  input wire logic pll_disable_strap_in,
  input wire logic load_strobe_n_in,
  input wire logic read_select_in,
  input wire logic [ADDR_W-1:0] address_in,
  input wire logic burst_lsb_address_in,
  input wire logic [LANES-1:0] byte_lane_mask_n_in,
  input wire logic [DATA_W-1:0] dq_in,
  output logic [DATA_W-1:0] dq_out,
  output logic dq_oe_n_out,
  output logic echo_clock_out,
  output logic echo_clock_n_out,
  input wire logic tck_in,
  input wire logic tms_in,
  input wire logic tdi_in,
  output logic tdo_out,
  output logic tdo_oe_n_out
);

  localparam int LANE_W = DATA_W / LANES;
  localparam int P_ADDR = `DDR2_SYNC_FIXED;
  localparam int P_MASK = P_ADDR + ADDR_W;
  localparam int P_DQ = P_MASK + LANES;
  localparam int SYNC_W = P_DQ + DATA_W;
  localparam int IR_W = `DDR2_TAP_IR_W;

  typedef struct packed {
    logic [SYNC_W-1:0] sync1;
    logic [SYNC_W-1:0] sync2;
    logic [3:0] clk_prev;
    logic tck_prev;
    logic block;
    ddr2_burst_pkg::wr_phase_type wr_phase;
    logic [ADDR_W-1:0] wr_addr;
    logic wr_lsb;
    logic we;
    logic [ADDR_W:0] waddr;
    logic [DATA_W-1:0] wdata;
    logic [LANES-1:0] wmask;
    logic rd_busy;
    logic rd_last;
    logic rd_strap;
    logic [2:0] rd_cnt;
    logic [DATA_W-1:0] rd_word0;
    logic [DATA_W-1:0] rd_word1;
    logic [DATA_W-1:0] dq;
    logic oe_n;
    logic echo;
    ddr2_burst_pkg::tap_state_type tap;
    logic [IR_W-1:0] ir;
    logic bypass;
    logic tdo;
    logic tdo_oe_n;
  } state_type;

  state_type s_reg;
  state_type s_next;
  logic [DATA_W-1:0] mem [0:(2**(ADDR_W+1))-1];

  // Linear burst of two: the second word flips the burst bit
  function automatic logic [ADDR_W:0] burst_index(
    input logic [ADDR_W-1:0] addr,
    input logic lsb,
    input logic second
  );
    burst_index = {addr, lsb ^ second};
  endfunction

  function automatic ddr2_burst_pkg::tap_state_type tap_step(
    input ddr2_burst_pkg::tap_state_type st,
    input logic tms
  );
    case (st)
      ddr2_burst_pkg::TAP_RESET:
        tap_step = tms ? ddr2_burst_pkg::TAP_RESET : ddr2_burst_pkg::TAP_IDLE;
      ddr2_burst_pkg::TAP_IDLE, ddr2_burst_pkg::TAP_UPD_DR,
      ddr2_burst_pkg::TAP_UPD_IR:
        tap_step = tms ? ddr2_burst_pkg::TAP_SEL_DR : ddr2_burst_pkg::TAP_IDLE;
      ddr2_burst_pkg::TAP_SEL_DR:
        tap_step = tms ? ddr2_burst_pkg::TAP_SEL_IR : ddr2_burst_pkg::TAP_CAP_DR;
      ddr2_burst_pkg::TAP_CAP_DR, ddr2_burst_pkg::TAP_SHIFT_DR,
      ddr2_burst_pkg::TAP_EXIT2_DR:
        tap_step = tms ? ddr2_burst_pkg::TAP_EXIT1_DR
                       : ddr2_burst_pkg::TAP_SHIFT_DR;
      ddr2_burst_pkg::TAP_EXIT1_DR:
        tap_step = tms ? ddr2_burst_pkg::TAP_UPD_DR : ddr2_burst_pkg::TAP_PAUSE_DR;
      ddr2_burst_pkg::TAP_PAUSE_DR:
        tap_step = tms ? ddr2_burst_pkg::TAP_EXIT2_DR
                       : ddr2_burst_pkg::TAP_PAUSE_DR;
      ddr2_burst_pkg::TAP_SEL_IR:
        tap_step = tms ? ddr2_burst_pkg::TAP_RESET : ddr2_burst_pkg::TAP_CAP_IR;
      ddr2_burst_pkg::TAP_CAP_IR, ddr2_burst_pkg::TAP_SHIFT_IR,
      ddr2_burst_pkg::TAP_EXIT2_IR:
        tap_step = tms ? ddr2_burst_pkg::TAP_EXIT1_IR
                       : ddr2_burst_pkg::TAP_SHIFT_IR;
      ddr2_burst_pkg::TAP_EXIT1_IR:
        tap_step = tms ? ddr2_burst_pkg::TAP_UPD_IR : ddr2_burst_pkg::TAP_PAUSE_IR;
      ddr2_burst_pkg::TAP_PAUSE_IR:
        tap_step = tms ? ddr2_burst_pkg::TAP_EXIT2_IR
                       : ddr2_burst_pkg::TAP_PAUSE_IR;
      default:
        tap_step = ddr2_burst_pkg::TAP_RESET;
    endcase
  endfunction

  // Only the second synchroniser stage is decoded
  logic [3:0] clk_now;
  logic [3:0] clk_rise;
  logic k_rise;
  logic kn_rise;
  logic o_rise;
  logic on_rise;
  logic cmd_take;
  logic rd_take;
  logic wr_take;
  logic tck_rise;
  logic tck_fall;
  logic [ADDR_W-1:0] cmd_addr;
  logic cmd_lsb;
  logic [2:0] first_edge;
  logic [2:0] edge_idx;

  assign clk_now = s_reg.sync2[3:0];
  assign clk_rise = clk_now & ~s_reg.clk_prev; // RQ12
  assign k_rise = clk_rise[`DDR2_SYNC_K];
  assign kn_rise = clk_rise[`DDR2_SYNC_KN];
  assign o_rise = s_reg.sync2[`DDR2_SYNC_USE_C] ? clk_rise[`DDR2_SYNC_C]
                                               : k_rise; // RQ3
  assign on_rise = s_reg.sync2[`DDR2_SYNC_USE_C] ? clk_rise[`DDR2_SYNC_CN]
                                                : kn_rise; // RQ3
  // Load strobe and direction are taken together on one edge
  assign cmd_take = k_rise && !s_reg.sync2[`DDR2_SYNC_LOAD_N]
                    && !s_reg.block; // RQ1 RQ14 RQ17
  assign rd_take = cmd_take && s_reg.sync2[`DDR2_SYNC_READ];
  assign wr_take = cmd_take && !s_reg.sync2[`DDR2_SYNC_READ];
  assign cmd_addr = s_reg.sync2[P_ADDR +: ADDR_W];
  assign cmd_lsb = s_reg.sync2[`DDR2_SYNC_LSB];
  assign tck_rise = s_reg.sync2[`DDR2_SYNC_TCK] && !s_reg.tck_prev;
  assign tck_fall = !s_reg.sync2[`DDR2_SYNC_TCK] && s_reg.tck_prev;
  assign first_edge = s_reg.rd_strap ? `DDR2_RL_HALF_PLL
                                     : `DDR2_RL_HALF_DLL; // RQ5 RQ6
  assign edge_idx = s_reg.rd_cnt + 3'h1;

  always_comb
  begin
    s_next = s_reg;
    // Every pin passes two flops before it is decoded
    s_next.sync1 = {dq_in, byte_lane_mask_n_in, address_in,
                    burst_lsb_address_in, tdi_in, tms_in, tck_in,
                    pll_disable_strap_in, out_clock_used_in,
                    read_select_in, load_strobe_n_in, c_clk_n_in,
                    c_clk_in, k_clk_n_in, k_clk_in}; // RQ9
    s_next.sync2 = s_reg.sync1; // RQ9
    s_next.clk_prev = clk_now;
    s_next.tck_prev = s_reg.sync2[`DDR2_SYNC_TCK];
    s_next.we = 1'b0;
    if (k_rise)
    begin
      s_next.block = cmd_take; // RQ1
    end

    case (s_reg.wr_phase)
      ddr2_burst_pkg::WR_IDLE:
        s_next.wr_phase = ddr2_burst_pkg::WR_IDLE;
      ddr2_burst_pkg::WR_WORD0:
        if (k_rise)
        begin
          s_next.we = 1'b1; // RQ11
          s_next.waddr = burst_index(s_reg.wr_addr, s_reg.wr_lsb, 1'b0); // RQ4
          s_next.wdata = s_reg.sync2[P_DQ +: DATA_W]; // RQ2
          s_next.wmask = ~s_reg.sync2[P_MASK +: LANES]; // RQ15
          s_next.wr_phase = ddr2_burst_pkg::WR_WORD1;
        end
      ddr2_burst_pkg::WR_WORD1:
        if (kn_rise)
        begin
          s_next.we = 1'b1; // RQ11
          s_next.waddr = burst_index(s_reg.wr_addr, s_reg.wr_lsb, 1'b1); // RQ4
          s_next.wdata = s_reg.sync2[P_DQ +: DATA_W]; // RQ2
          s_next.wmask = ~s_reg.sync2[P_MASK +: LANES]; // RQ15
          s_next.wr_phase = ddr2_burst_pkg::WR_IDLE;
        end
      default:
        s_next.wr_phase = ddr2_burst_pkg::WR_IDLE;
    endcase
    if (wr_take)
    begin
      s_next.wr_phase = ddr2_burst_pkg::WR_WORD0;
      s_next.wr_addr = cmd_addr;
      s_next.wr_lsb = cmd_lsb;
    end

    // Output half-edges drive data, echo follows the same clock
    s_next.echo = s_reg.sync2[`DDR2_SYNC_USE_C] ? clk_now[`DDR2_SYNC_C]
                                               : clk_now[`DDR2_SYNC_K]; // RQ7
    if (o_rise || on_rise)
    begin
      if (s_reg.rd_cnt != 3'h7)
      begin
        s_next.rd_cnt = edge_idx;
      end
      if (s_reg.rd_last)
      begin
        s_next.oe_n = 1'b1; // RQ16 RQ8
        s_next.rd_last = 1'b0;
      end
      if (s_reg.rd_busy && edge_idx == first_edge)
      begin
        s_next.dq = s_reg.rd_word0; // RQ10 RQ5 RQ6
        s_next.oe_n = 1'b0;
      end
      else if (s_reg.rd_busy && edge_idx == first_edge + 3'h1)
      begin
        s_next.dq = s_reg.rd_word1; // RQ10
        s_next.rd_busy = 1'b0;
        s_next.rd_last = 1'b1;
      end
    end
    // A new read may land on the edge that sends the old second word
    if (rd_take)
    begin
      s_next.rd_busy = 1'b1;
      s_next.rd_cnt = 3'h0;
      s_next.rd_strap = s_reg.sync2[`DDR2_SYNC_STRAP];
      s_next.rd_word0 = mem[burst_index(cmd_addr, cmd_lsb, 1'b0)]; // RQ4
      s_next.rd_word1 = mem[burst_index(cmd_addr, cmd_lsb, 1'b1)]; // RQ4
    end

    // Only bypass is implemented behind the instruction register
    if (tck_rise)
    begin
      s_next.tap = tap_step(s_reg.tap, s_reg.sync2[`DDR2_SYNC_TMS]); // RQ13
      case (s_reg.tap)
        ddr2_burst_pkg::TAP_RESET:
          s_next.ir = `DDR2_TAP_IR_RESET;
        ddr2_burst_pkg::TAP_CAP_IR:
          s_next.ir = `DDR2_TAP_IR_CAPTURE;
        ddr2_burst_pkg::TAP_SHIFT_IR:
          s_next.ir = {s_reg.sync2[`DDR2_SYNC_TDI], s_reg.ir[IR_W-1:1]};
        ddr2_burst_pkg::TAP_CAP_DR:
          s_next.bypass = 1'b0;
        ddr2_burst_pkg::TAP_SHIFT_DR:
          s_next.bypass = s_reg.sync2[`DDR2_SYNC_TDI];
        default:
          s_next.bypass = s_reg.bypass;
      endcase
    end
    if (tck_fall)
    begin
      s_next.tdo = (s_reg.tap == ddr2_burst_pkg::TAP_SHIFT_IR) ? s_reg.ir[0]
                                                              : s_reg.bypass;
      s_next.tdo_oe_n = !(s_reg.tap == ddr2_burst_pkg::TAP_SHIFT_IR
                        || s_reg.tap == ddr2_burst_pkg::TAP_SHIFT_DR); // RQ13
    end
  end

  always_ff @(posedge sys_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      s_reg <= '0;
      // Idle levels, so no false clock edge or strobe follows reset
      s_reg.sync1[`DDR2_SYNC_KN] <= 1'b1;
      s_reg.sync1[`DDR2_SYNC_CN] <= 1'b1;
      s_reg.sync1[`DDR2_SYNC_LOAD_N] <= 1'b1;
      s_reg.sync2[`DDR2_SYNC_KN] <= 1'b1;
      s_reg.sync2[`DDR2_SYNC_CN] <= 1'b1;
      s_reg.sync2[`DDR2_SYNC_LOAD_N] <= 1'b1;
      s_reg.clk_prev <= `DDR2_CLK_IDLE;
      s_reg.oe_n <= 1'b1;
      s_reg.tdo_oe_n <= 1'b1;
      s_reg.tap <= ddr2_burst_pkg::TAP_RESET;
      s_reg.ir <= `DDR2_TAP_IR_RESET;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  // Array has no reset; lanes with a clear mask keep their contents
  always_ff @(posedge sys_clk_in)
  begin
    if (s_reg.we)
    begin
      for (int i = 0; i < LANES; i++)
      begin
        if (s_reg.wmask[i])
        begin
          mem[s_reg.waddr][i*LANE_W +: LANE_W] <=
            s_reg.wdata[i*LANE_W +: LANE_W]; // RQ15 RQ11
        end
      end
    end
  end

  assign dq_out = s_reg.dq;
  assign dq_oe_n_out = s_reg.oe_n;
  assign echo_clock_out = s_reg.echo;
  assign echo_clock_n_out = ~s_reg.echo;
  assign tdo_out = s_reg.tdo;
  assign tdo_oe_n_out = s_reg.tdo_oe_n;

  logic [2:0] lat_cnt;
  always_ff @(posedge sys_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      lat_cnt <= 3'h0;
    else if (rd_take)
      lat_cnt <= 3'h0;
    else if ((o_rise || on_rise) && lat_cnt != 3'h7)
      lat_cnt <= lat_cnt + 3'h1;
  end

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rstn_in);

  AST_ONE_CMD: assert property (cmd_take |=> (!cmd_take) [*8]) // RQ1
    else $error("second address taken inside one burst");
  AST_WR_WORD0: assert property ((s_reg.wr_phase == ddr2_burst_pkg::WR_WORD0
    && k_rise) |=> (s_reg.we && s_reg.waddr[0] == $past(s_reg.wr_lsb))) // RQ2
    else $error("first write word not stored at burst address");
  AST_WR_WORD1: assert property ((s_reg.wr_phase == ddr2_burst_pkg::WR_WORD1
    && kn_rise) |=> (s_reg.we && s_reg.waddr[0] != $past(s_reg.wr_lsb))) // RQ4
    else $error("second write word not stored at flipped address");
  AST_BYTE_MASK: assert property (s_reg.we |->
    s_reg.wmask == ~$past(s_reg.sync2[P_MASK +: LANES])) // RQ15
    else $error("write lane mask not taken with its word");
  AST_WR_NO_DRIVE: assert property ((k_rise && s_reg.wr_phase ==
    ddr2_burst_pkg::WR_WORD0) |-> dq_oe_n_out) // RQ8
    else $error("data bus driven while write data arrives");
  AST_RD_EDGE: assert property ($fell(dq_oe_n_out) |->
    $past(o_rise || on_rise)) // RQ3
    else $error("read data started off an output clock edge");
  AST_LAT_PLL: assert property (($fell(dq_oe_n_out) && s_reg.rd_strap) |->
    lat_cnt == 3'h3) // RQ5
    else $error("read latency not 1.5 cycles with strap high");
  AST_LAT_DLL: assert property (($fell(dq_oe_n_out) && !s_reg.rd_strap) |->
    lat_cnt == 3'h2) // RQ6
    else $error("read latency not 1 cycle with strap low");
  AST_ECHO_ALIGN: assert property (($changed(dq_out) && !dq_oe_n_out) |->
    $changed(echo_clock_out)) // RQ7
    else $error("read data changed without an echo edge");
  AST_BUS_RELEASE: assert property ($fell(dq_oe_n_out) |->
    ##[1:12] dq_oe_n_out) // RQ16
    else $error("data bus not released after a burst");
  AST_TAP_HIZ: assert property ((s_reg.tap == ddr2_burst_pkg::TAP_RESET
    && $past(s_reg.tap) == ddr2_burst_pkg::TAP_RESET) |=> tdo_oe_n_out) // RQ13
    else $error("test data out driven in reset state");

  COV_RD_PLL: cover property ($fell(dq_oe_n_out) && s_reg.rd_strap);
  COV_RD_DLL: cover property ($fell(dq_oe_n_out) && !s_reg.rd_strap);
  COV_WRITE: cover property (s_reg.we && s_reg.wr_phase ==
    ddr2_burst_pkg::WR_IDLE);
  COV_RD_B2B: cover property (rd_take && s_reg.rd_busy);

endmodule

// *** mem_ctrl_model.sv ***
module mem_ctrl_model #(
  parameter int DATA_W = 36,
  parameter int LANES = 4,
  parameter int ADDR_W = 4
) (
  input wire logic sys_clk_in,
  input wire logic use_c_in,
  input wire logic oe_n_in,
  input wire logic [DATA_W-1:0] bus_in,
  input wire logic echo_in,
  input wire logic echo_n_in,
  output logic k_out,
  output logic k_n_out,
  output logic c_out,
  output logic c_n_out,
  output logic ld_n_out,
  output logic rd_out,
  output logic [ADDR_W-1:0] addr_out,
  output logic lsb_out,
  output logic [LANES-1:0] mask_n_out,
  output logic [DATA_W-1:0] dq_out,
  output logic drive_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic s_oe [10];
  logic s_echo [10];
  logic s_echo_n [10];
  logic [DATA_W-1:0] s_dq [10];
  logic clash;
  initial
  begin
    k_out = 1'b0;
    k_n_out = 1'b1;
    c_out = 1'b0;
    c_n_out = 1'b1;
    ld_n_out = 1'b1;
    rd_out = 1'b0;
    addr_out = '0;
    lsb_out = 1'b0;
    mask_n_out = '1;
    dq_out = '0;
    drive_out = 1'b0;
    clash = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_in);
    #1;
  endtask
  // Clocks move only inside a burst; c stands still in single clock mode
  task automatic toggle();
    k_out = ~k_out;
    k_n_out = ~k_n_out;
    if (use_c_in)
    begin
      c_out = k_out;
      c_n_out = k_n_out;
    end
  endtask
  task automatic burst(input logic is_rd, input logic [ADDR_W-1:0] a,
    input logic l, input logic [DATA_W-1:0] w0,
    input logic [DATA_W-1:0] w1, input logic [LANES-1:0] m0,
    input logic [LANES-1:0] m1, input logic twice);
    ld_n_out = 1'b0;
    rd_out = is_rd;
    addr_out = a;
    lsb_out = l;
    tick(4);
    for (int i = 0; i < 10; i++)
    begin
      toggle();
      if (i == 1)
      begin
        ld_n_out = !twice;
        addr_out = ~a;
      end
      if (i == 3)
        ld_n_out = 1'b1;
      if (!is_rd && (i == 1 || i == 3))
      begin
        dq_out = (i == 1) ? w0 : w1;
        mask_n_out = (i == 1) ? m0 : m1;
        drive_out = 1'b1;
      end
      if (i == 5 && drive_out)
      begin
        // Inverse of the last word, so a stale capture cannot match
        dq_out = ~dq_out;
        mask_n_out = '1;
        drive_out = 1'b0;
      end
      tick(2);
      s_oe[i] = oe_n_in;
      s_dq[i] = bus_in;
      s_echo[i] = echo_in;
      s_echo_n[i] = echo_n_in;
      clash = clash | (drive_out & ~oe_n_in);
      tick(2);
    end
  endtask
endmodule

// *** testbench.sv ***
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int DW = 36;
  localparam int AW = 4;
  logic sys_clk, rstn, use_c, strap, tck, tms, tdi;
  logic k_clk, k_clk_n, c_clk, c_clk_n, load_strobe_n, read_select;
  logic [AW-1:0] address;
  logic burst_lsb_address;
  logic [3:0] byte_lane_mask_n;
  logic [DW-1:0] ctrl_dq, dev_dq, dq_bus, w0, w1, x0, x1, e0, e1;
  logic ctrl_drive, dev_oe_n, echo, echo_n, tdo, tdo_oe_n;
  int n_mismatch, num_checks;
  // A bus nobody drives shows the inverse of the last read word
  assign dq_bus = !dev_oe_n ? dev_dq
                : (ctrl_drive ? ctrl_dq : ~dev_dq);
  ddr2_burst2_sram_port #(.DATA_W(DW), .LANES(4), .ADDR_W(AW)) u_dut (
    .sys_clk_in(sys_clk), .rstn_in(rstn),
    .k_clk_in(k_clk), .k_clk_n_in(k_clk_n),
    .c_clk_in(c_clk), .c_clk_n_in(c_clk_n),
    .out_clock_used_in(use_c), .pll_disable_strap_in(strap),
    .load_strobe_n_in(load_strobe_n), .read_select_in(read_select),
    .address_in(address), .burst_lsb_address_in(burst_lsb_address),
    .byte_lane_mask_n_in(byte_lane_mask_n), .dq_in(dq_bus),
    .dq_out(dev_dq), .dq_oe_n_out(dev_oe_n),
    .echo_clock_out(echo), .echo_clock_n_out(echo_n),
    .tck_in(tck), .tms_in(tms), .tdi_in(tdi),
    .tdo_out(tdo), .tdo_oe_n_out(tdo_oe_n)
  );
  // The model's default geometry is the one this bench uses
  mem_ctrl_model u_ctrl (
    .sys_clk_in(sys_clk), .use_c_in(use_c), .oe_n_in(dev_oe_n),
    .bus_in(dq_bus), .echo_in(echo), .echo_n_in(echo_n),
    .k_out(k_clk), .k_n_out(k_clk_n), .c_out(c_clk), .c_n_out(c_clk_n),
    .ld_n_out(load_strobe_n), .rd_out(read_select),
    .addr_out(address), .lsb_out(burst_lsb_address),
    .mask_n_out(byte_lane_mask_n), .dq_out(ctrl_dq),
    .drive_out(ctrl_drive)
  );
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic close_out();
    if (n_mismatch == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic check(input string name, input logic [DW-1:0] seen,
    input logic [DW-1:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  function automatic logic [DW-1:0] merge(input logic [DW-1:0] old_w,
    input logic [DW-1:0] new_w, input logic [3:0] m);
    merge = old_w;
    for (int j = 0; j < 4; j++)
      if (!m[j])
        merge[j*9 +: 9] = new_w[j*9 +: 9];
  endfunction
  // Sample i shows the state left by half-edge i-1 of the burst
  task automatic check_read(input logic lat, input logic [DW-1:0] r0,
    input logic [DW-1:0] r1);
    int b;
    b = lat ? 4 : 3;
    for (int i = 0; i < 10; i++)
    begin
      check("oe_n", u_ctrl.s_oe[i], !(i == b || i == b + 1));
      check("echo", u_ctrl.s_echo[i], (i % 2 == 1));
      check("echo_n", u_ctrl.s_echo_n[i], (i % 2 == 0));
    end
    check("word0", u_ctrl.s_dq[b], r0);
    check("word1", u_ctrl.s_dq[b + 1], r1);
  endtask
  task automatic sc_plain();
    use_c = 1'b0;
    strap = 1'b0;
    u_ctrl.burst(0, 3, 0, w0, w1, 4'h0, 4'h0, 0);
    u_ctrl.burst(1, 3, 0, '0, '0, 4'hF, 4'hF, 0);
    check_read(0, w0, w1);
  endtask
  task automatic sc_swap();
    use_c = 1'b1;
    strap = 1'b1;
    u_ctrl.burst(1, 3, 1, '0, '0, 4'hF, 4'hF, 0);
    check_read(1, w1, w0);
  endtask
  task automatic sc_mask();
    use_c = 1'b0;
    strap = 1'b0;
    e0 = merge(w0, x1, 4'hE);
    e1 = merge(w1, x0, 4'h5);
    u_ctrl.burst(0, 3, 1, x0, x1, 4'h5, 4'hE, 0);
    u_ctrl.burst(1, 3, 0, '0, '0, 4'hF, 4'hF, 0);
    check_read(0, e0, e1);
  endtask
  // The strobe held on the next k edge points at an unwritten address
  task automatic sc_refuse();
    u_ctrl.burst(1, 3, 0, '0, '0, 4'hF, 4'hF, 1);
    check_read(0, e0, e1);
  endtask
  task automatic tap_step(input logic m);
    tms = m;
    u_ctrl.tick(4);
    tck = 1'b1;
    u_ctrl.tick(8);
    tck = 1'b0;
    u_ctrl.tick(8);
  endtask
  task automatic sc_tap();
    logic [9:0] path;
    path = 10'h0DF;
    check("tdo_oe_n", tdo_oe_n, 1'b1);
    for (int i = 0; i < 10; i++)
      tap_step(path[i]);
    check("tdo", tdo, 1'b1);
    check("tdo_oe_n", tdo_oe_n, 1'b0);
    tdi = 1'b1;
    tap_step(1'b0);
    check("tdo", tdo, 1'b0);
    tdi = 1'b0;
    tap_step(1'b0);
    check("tdo", tdo, 1'b0);
    // The bit shifted in leaves the 3-bit instruction register here
    tap_step(1'b0);
    check("tdo", tdo, 1'b1);
    tap_step(1'b1);
    check("tdo_oe_n", tdo_oe_n, 1'b1);
    // Update, select the data path, capture, then shift through bypass
    path = 10'h003;
    tdi = 1'b1;
    for (int i = 0; i < 4; i++)
      tap_step(path[i]);
    check("tdo", tdo, 1'b0);
    check("tdo_oe_n", tdo_oe_n, 1'b0);
    tap_step(1'b0);
    check("tdo", tdo, 1'b1);
    tdi = 1'b0;
  endtask
  initial
  begin
    n_mismatch = 0;
    num_checks = 0;
    rstn = 1'b0;
    use_c = 1'b0;
    strap = 1'b0;
    tck = 1'b0;
    tms = 1'b0;
    tdi = 1'b0;
    w0 = 36'h123456789;
    w1 = 36'hFEDCBA987;
    x0 = 36'hA5A5A5A5A;
    x1 = 36'h5A5A5A5A5;
    repeat (20) @(posedge sys_clk);
    #1;
    rstn = 1'b1;
    u_ctrl.tick(5);
    sc_plain();
    sc_swap();
    sc_mask();
    sc_refuse();
    sc_tap();
    check("clash", u_ctrl.clash, 1'b0);
    close_out();
  end
  // Whole run is about 700 cycles; this leaves ample margin
  initial
  begin
    #30000;
    n_mismatch++;
    close_out();
  end
endmodule
